// *** verilog/tsenc_pkg.sv ***
// constants and types for the tri-state address/data encoder
package tsenc_pkg;

  // ******************************************************
  // clock and timing
  // ******************************************************
  localparam int          CLK_HZ       = 200000000;
  localparam int          ENC_OSC_HZ   = 70000;
  // one encoder oscillator period, rounded down
  localparam logic [11:0] OSC_CYC      = 12'(CLK_HZ / ENC_OSC_HZ);
  localparam int          SETTLE_NS    = 1000;
  localparam int          CLK_PERIOD_NS = 5;
  // least time: round up
  localparam logic [7:0]  SETTLE_CYC   =
    8'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          CYCLE_LAG_MS = 150;

  // ******************************************************
  // packet layout
  // ******************************************************
  localparam int         N_ADDR      = 10;
  localparam int         N_DATA      = 8;
  localparam int         N_LINES     = N_ADDR + N_DATA;
  localparam logic [5:0] LAST_ELEM   = 6'h24;
  localparam logic [5:0] SYNC_SLOTS  = 6'h24;
  localparam logic [5:0] BIT_SLOTS   = 6'h04;
  localparam logic [5:0] SYNC_HIGH   = 6'h01;
  localparam logic [5:0] ONE_HIGH    = 6'h03;
  localparam logic [5:0] ZERO_HIGH   = 6'h01;
  localparam logic [1:0] LAST_WORD   = 2'h2;

  // tri-state symbol codes: first bit sent is [1], second is [0]
  localparam logic [1:0] SYM_LOW     = 2'h0;
  localparam logic [1:0] SYM_FLOAT   = 2'h1;
  localparam logic [1:0] SYM_HIGH    = 2'h3;

  typedef struct packed {
    logic [2*N_DATA-1:0] data_codes;
    logic [2*N_ADDR-1:0] addr_codes;
  } tsenc_frame_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h1,
    ST_PROBE_HI = 4'h2,
    ST_PROBE_LO = 4'h4,
    ST_SEND     = 4'h8
  } tsenc_state_t;

endpackage

// *** verilog/tsenc_encoder.sv ***
// serial tri-state address/data encoder keying the radio modulator
`timescale 1ns/1ps
// clocks per oscillator slot; a bench may shorten it to keep runs brief
module tsenc_encoder #(
  parameter logic [11:0] OSC_DIV = tsenc_pkg::OSC_CYC
) (
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  input  wire logic                        transmit_enable,
  input  wire logic [tsenc_pkg::N_ADDR-1:0] tristate_select_lines,
  input  wire logic [tsenc_pkg::N_DATA-1:0] parallel_input_lines,
  output logic                             line_pull_en,
  output logic                             line_pull_up,
  output logic                             rf_output,
  output logic                             encoder_busy
);

  // ******************************************************
  // input synchronisers
  // ******************************************************
  logic                         te_m_q;
  logic                         te_s_q;
  logic [tsenc_pkg::N_LINES-1:0] lines_m_q;
  logic [tsenc_pkg::N_LINES-1:0] lines_s_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      te_m_q    <= 1'b0;
      te_s_q    <= 1'b0;
      lines_m_q <= '0;
      lines_s_q <= '0;
    end else begin
      te_m_q    <= transmit_enable;
      te_s_q    <= te_m_q;
      lines_m_q <= {parallel_input_lines, tristate_select_lines};
      lines_s_q <= lines_m_q;
    end
  end

  // ******************************************************
  // helpers
  // ******************************************************
  // a line that follows the pull both ways is floating; a line that
  // opposes it both ways is read as low (pin fights its own pull)
  function automatic logic [1:0] sym_code(input logic hi,
                                          input logic lo);
    if (hi && lo)
      sym_code = tsenc_pkg::SYM_HIGH;
    else if (hi && !lo)
      sym_code = tsenc_pkg::SYM_FLOAT;
    else
      sym_code = tsenc_pkg::SYM_LOW;
  endfunction

  // modulator level for one slot of a word element
  function automatic logic elem_level(input logic [5:0] elem,
                                      input logic [5:0] slot,
                                      input logic [35:0] codes);
    logic [5:0] idx;
    idx = elem - 6'h01;
    if (elem == 6'h00)
      elem_level = (slot < tsenc_pkg::SYNC_HIGH);
    else if (codes[{idx[5:1], ~idx[0]}])
      elem_level = (slot < tsenc_pkg::ONE_HIGH);
    else
      elem_level = (slot < tsenc_pkg::ZERO_HIGH);
  endfunction

  // ******************************************************
  // sequencer
  // ******************************************************
  tsenc_pkg::tsenc_state_t       state_q,  state_d;
  tsenc_pkg::tsenc_frame_t       frame_q,  frame_d;
  logic [tsenc_pkg::N_LINES-1:0] hi_q,     hi_d;
  logic [7:0]                    settle_q, settle_d;
  logic [11:0]                   div_q,    div_d;
  logic [5:0]                    slot_q,   slot_d;
  logic [5:0]                    elem_q,   elem_d;
  logic [1:0]                    word_q,   word_d;
  logic                          rf_q,     rf_d;
  logic                          pen_q,    pen_d;
  logic                          pup_q,    pup_d;
  logic                          busy_q,   busy_d;
  logic                          tick;
  logic                          elem_end;
  logic                          cycle_end;
  logic                          settled;
  logic [35:0]                   codes;

  assign codes    = {frame_q.data_codes, frame_q.addr_codes};
  assign tick     = (div_q == OSC_DIV - 12'h001);
  assign settled  = (settle_q == tsenc_pkg::SETTLE_CYC);
  assign elem_end = tick && (slot_q == ((elem_q == 6'h00) ?
                    tsenc_pkg::SYNC_SLOTS - 6'h01 :
                    tsenc_pkg::BIT_SLOTS - 6'h01));
  assign cycle_end = elem_end && (elem_q == tsenc_pkg::LAST_ELEM) &&
                     (word_q == tsenc_pkg::LAST_WORD);

  always_comb begin
    state_d  = state_q;
    frame_d  = frame_q;
    hi_d     = hi_q;
    settle_d = settle_q;
    div_d    = 12'h000;
    slot_d   = 6'h00;
    elem_d   = 6'h00;
    word_d   = 2'h0;
    rf_d     = 1'b0;
    pen_d    = 1'b0;
    pup_d    = 1'b0;
    unique case (state_q)
      tsenc_pkg::ST_IDLE: begin
        settle_d = 8'h00;
        if (te_s_q) begin
          state_d = tsenc_pkg::ST_PROBE_HI;
          pen_d   = 1'b1;
          pup_d   = 1'b1;
        end
      end
      tsenc_pkg::ST_PROBE_HI: begin
        pen_d    = 1'b1;
        pup_d    = 1'b1;
        settle_d = settle_q + 8'h01;
        if (settled) begin
          hi_d     = lines_s_q;
          settle_d = 8'h00;
          pup_d    = 1'b0;
          state_d  = tsenc_pkg::ST_PROBE_LO;
        end
      end
      tsenc_pkg::ST_PROBE_LO: begin
        pen_d    = 1'b1;
        settle_d = settle_q + 8'h01;
        if (settled) begin
          for (int i = 0; i < tsenc_pkg::N_LINES; i++) begin
            if (i < tsenc_pkg::N_ADDR)
              frame_d.addr_codes[2*i +: 2] = sym_code(hi_q[i],
                                                      lines_s_q[i]);
            else
              frame_d.data_codes[2*(i-tsenc_pkg::N_ADDR) +: 2] =
                sym_code(hi_q[i], lines_s_q[i]);
          end
          settle_d = 8'h00;
          pen_d    = 1'b0;
          state_d  = tsenc_pkg::ST_SEND;
        end
      end
      tsenc_pkg::ST_SEND: begin
        div_d  = tick ? 12'h000 : div_q + 12'h001;
        slot_d = tick ? slot_q + 6'h01 : slot_q;
        elem_d = elem_q;
        word_d = word_q;
        if (elem_end) begin
          slot_d = 6'h00;
          elem_d = elem_q + 6'h01;
          if (elem_q == tsenc_pkg::LAST_ELEM) begin
            elem_d = 6'h00;
            word_d = word_q + 2'h1;
          end
        end
        rf_d = elem_level(elem_d, slot_d, codes);
        if (cycle_end) begin
          rf_d   = 1'b0;
          word_d = 2'h0;
          if (te_s_q) begin
            state_d = tsenc_pkg::ST_PROBE_HI;
            pen_d   = 1'b1;
            pup_d   = 1'b1;
          end else begin
            state_d = tsenc_pkg::ST_IDLE;
          end
        end
      end
    endcase
    busy_d = (state_d != tsenc_pkg::ST_IDLE);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= tsenc_pkg::ST_IDLE;
      frame_q  <= '0;
      hi_q     <= '0;
      settle_q <= 8'h00;
      div_q    <= 12'h000;
      slot_q   <= 6'h00;
      elem_q   <= 6'h00;
      word_q   <= 2'h0;
      rf_q     <= 1'b0;
      pen_q    <= 1'b0;
      pup_q    <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      frame_q  <= frame_d;
      hi_q     <= hi_d;
      settle_q <= settle_d;
      div_q    <= div_d;
      slot_q   <= slot_d;
      elem_q   <= elem_d;
      word_q   <= word_d;
      rf_q     <= rf_d;
      pen_q    <= pen_d;
      pup_q    <= pup_d;
      busy_q   <= busy_d;
    end
  end

  // the sync of word 0 starts on the first send cycle; level goes high one cycle later
  assign rf_output    = rf_q;
  assign line_pull_en = pen_q;
  assign line_pull_up = pup_q;
  assign encoder_busy = busy_q;

  // ******************************************************
  // checks
  // ******************************************************
  a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_q == tsenc_pkg::ST_IDLE |-> !rf_q && !pen_q)
    else $error("output active while idle");

  a_start_capture: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state_q == tsenc_pkg::ST_IDLE && te_s_q
    |=> state_q == tsenc_pkg::ST_PROBE_HI && pen_q && pup_q)
    else $error("enable did not start capture");

  a_three_words: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    word_q <= tsenc_pkg::LAST_WORD)
    else $error("word count past three");

  a_cycle_restart: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state_q == tsenc_pkg::ST_SEND && cycle_end && te_s_q
    |=> state_q == tsenc_pkg::ST_PROBE_HI)
    else $error("cycle not restarted");

  a_finish_cycle: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state_q == tsenc_pkg::ST_SEND && !cycle_end
    |=> state_q == tsenc_pkg::ST_SEND)
    else $error("cycle cut short");

  a_stop_after: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state_q == tsenc_pkg::ST_SEND && cycle_end && !te_s_q
    |=> state_q == tsenc_pkg::ST_IDLE ##1 !rf_q)
    else $error("no stop after cycle");

  a_first_symbol: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state_q == tsenc_pkg::ST_SEND && elem_q == 6'h01 && slot_q == 6'h01
    && !tick |=> rf_q == frame_q.addr_codes[1])
    else $error("address 0 not sent first");

  a_sync_gap: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_q == tsenc_pkg::ST_SEND && elem_q == 6'h00 &&
    slot_q >= tsenc_pkg::SYNC_HIGH && !elem_end |=> !rf_q)
    else $error("sync period not low");

  a_float_code: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    state_q == tsenc_pkg::ST_PROBE_LO && settled &&
    hi_q[0] && !lines_s_q[0]
    |=> frame_q.addr_codes[1:0] == tsenc_pkg::SYM_FLOAT)
    else $error("floating line misencoded");

  a_resample: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(state_q == tsenc_pkg::ST_SEND)
    |-> $past(state_q) == tsenc_pkg::ST_PROBE_LO)
    else $error("cycle sent without fresh sample");

endmodule

// *** tb/tsenc_rx_model.sv ***
// receiver model: decodes the keyed stream, checks address, copies data
`timescale 1ns/1ps
module tsenc_rx_model #(
  parameter int OSC = int'(tsenc_pkg::OSC_CYC)
) (
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  input  wire logic                     rf_output,
  input  wire logic [19:0]              local_codes,
  output tsenc_pkg::tsenc_frame_t       rx_frame,
  output logic [7:0]                    data_out,
  output logic [7:0]                    accept_cnt,
  output logic [7:0]                    reject_cnt
);
  // ******************************************************
  // pulse width decoder
  // ******************************************************
  int          run;
  int          nbits;
  logic        prev;
  logic [35:0] sr;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run = 0;
      nbits = 36;
      prev = 1'b0;
      sr = '0;
      rx_frame = '0;
      data_out = '0;
      accept_cnt = '0;
      reject_cnt = '0;
    end else if (rf_output !== prev) begin
      // a long low gap means the sync pulse just went by
      if (rf_output && run > 8 * OSC) begin
        nbits = 0;
      end
      if (!rf_output && nbits < 36) begin
        // long high is a one, short high a zero
        sr = {sr[34:0], run > 2 * OSC};
        nbits++;
        if (nbits == 36) begin
          for (int i = 0; i < 18; i++) begin
            rx_frame[2*i +: 2] = sr[34-2*i +: 2];
          end
          if (rx_frame.addr_codes === local_codes) begin
            accept_cnt++;
            for (int j = 0; j < 8; j++) begin
              data_out[j] = rx_frame.data_codes[2*j +: 2] === 2'h3;
            end
          end else begin
            reject_cnt++;
          end
        end
      end
      prev = rf_output;
      run = 1;
    end else begin
      run++;
    end
  end
endmodule

// *** tb/tsenc_encoder_test.sv ***
// self-checking bench for the tri-state encoder with a receiver model
`timescale 1ns/1ps
module tsenc_encoder_test;
  // ******************************************************
  // pins, design and receiver
  // ******************************************************
  logic                    sys_clk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    transmit_enable = 1'b0;
  logic [9:0]              tristate_select_lines = '0;
  logic [7:0]              parallel_input_lines = '0;
  logic                    line_pull_en, line_pull_up, rf_output;
  logic                    encoder_busy;
  logic [1:0]              st [18];
  logic [19:0]             local_codes = '0;
  tsenc_pkg::tsenc_frame_t rx_frame;
  logic [7:0]              data_out, accept_cnt, reject_cnt, old;
  logic [31:0]             lfsr = 32'ha559;
  int                      miscompares = 0;
  int                      compares = 0;
  int                      cycles = 0;
  // short slots so four whole cycles fit the run budget
  localparam logic [11:0]  TB_OSC = 12'h010;
  always #2.5 sys_clk = ~sys_clk;
  tsenc_encoder #(.OSC_DIV(TB_OSC)) tsenc_encoder_inst (.sys_clk(sys_clk),
    .resetn(resetn),
    .transmit_enable(transmit_enable),
    .tristate_select_lines(tristate_select_lines),
    .parallel_input_lines(parallel_input_lines),
    .line_pull_en(line_pull_en), .line_pull_up(line_pull_up),
    .rf_output(rf_output), .encoder_busy(encoder_busy));
  tsenc_rx_model #(.OSC(int'(TB_OSC))) tsenc_rx_model_inst (
    .sys_clk(sys_clk), .resetn(resetn),
    .rf_output(rf_output), .local_codes(local_codes), .rx_frame(rx_frame),
    .data_out(data_out), .accept_cnt(accept_cnt), .reject_cnt(reject_cnt));
  // states: 0 low, 1 high, 2 floating; a floating pin follows the pull
  function automatic logic pin(logic [1:0] s);
    return s == 2'h2 ? line_pull_en & line_pull_up : s[0];
  endfunction
  always @(negedge sys_clk) begin
    for (int i = 0; i < 10; i++) tristate_select_lines[i] <= pin(st[i]);
    for (int i = 0; i < 8; i++) parallel_input_lines[i] <= pin(st[10+i]);
  end
  // a cycle is 540 slots of 16 clocks plus probing; four cycles are run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      results();
    end
  end
  // ******************************************************
  // expectations and helpers
  // ******************************************************
  function automatic logic [1:0] code(logic [1:0] s);
    return s == 2'h1 ? 2'h3 : s == 2'h2 ? 2'h1 : 2'h0;
  endfunction
  function automatic logic [19:0] exp_addr();
    logic [19:0] a;
    for (int i = 0; i < 10; i++) a[2*i +: 2] = code(st[i]);
    return a;
  endfunction
  function automatic logic [7:0] exp_data();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) d[i] = st[10+i] == 2'h1;
    return d;
  endfunction
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic randomise(int first);
    for (int i = first; i < 18; i++) begin
      lfsr = lfsr_next(lfsr);
      st[i] = 2'(lfsr % 3);
    end
  endtask
  task automatic check(string what, logic [19:0] exp, logic [19:0] got);
    compares++;
    if (exp !== got) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_count(logic [7:0] n);
    while (accept_cnt + reject_cnt < n) @(negedge sys_clk);
  endtask
  task automatic wait_idle();
    while (encoder_busy !== 1'b0) @(negedge sys_clk);
    repeat (500) @(negedge sys_clk);
    check("rf idle", 20'h0, 20'({rf_output, encoder_busy}));
  endtask
  task automatic pulse();
    transmit_enable = 1'b1;
    repeat (10) @(negedge sys_clk);
    transmit_enable = 1'b0;
    wait_idle();
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ******************************************************
  // scenarios
  // ******************************************************
  initial begin
    for (int i = 0; i < 18; i++) st[i] = 2'h2;
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    // short enable pulse still gives one whole three-word cycle
    randomise(0);
    st[0] = 2'h2;
    st[17] = 2'h2;
    local_codes = exp_addr();
    pulse();
    check("words", 20'd3, 20'(accept_cnt));
    check("addr", exp_addr(), rx_frame.addr_codes);
    check("data", 20'(exp_data()), 20'(data_out));
    // one address symbol off at the receiver: nothing taken
    old = data_out;
    randomise(0);
    local_codes = exp_addr();
    local_codes[1:0] = code(2'((st[0] + 2'h1) % 3));
    pulse();
    check("rejects", 20'd3, 20'(reject_cnt));
    check("held data", 20'(old), 20'(data_out));
    // enable held: data change shows only in the next cycle
    local_codes = exp_addr();
    old = exp_data();
    transmit_enable = 1'b1;
    wait_count(8'd7);
    randomise(10);
    st[10] = {1'b0, ~old[0]};
    wait_count(8'd9);
    check("old data", 20'(old), 20'(data_out));
    wait_count(8'd10);
    check("new data", 20'(exp_data()), 20'(data_out));
    transmit_enable = 1'b0;
    wait_idle();
    check("accepts", 20'd9, 20'(accept_cnt));
    results();
  end
endmodule
